// ### design/ppp_defines.vh
/*
 Constants for the parallel programming port: action codes, command bytes,
 storage sizes, reset values and entry timing.
 Assumes a 20 MHz mclk; counts are derived from times in ns.
*/
`ifndef PPP_DEFINES_VH
`define PPP_DEFINES_VH

`define PPP_CLK_NS 50
`define PPP_ACT_ADDR 2'b00
`define PPP_ACT_DATA 2'b01
`define PPP_ACT_CMD 2'b10
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WFUSE 8'h40
`define PPP_CMD_WLOCK 8'h20
`define PPP_CMD_WFLASH 8'h10
`define PPP_CMD_WEE 8'h11
`define PPP_CMD_RSIG 8'h08
`define PPP_CMD_RFUSE 8'h04
`define PPP_CMD_RFLASH 8'h02
`define PPP_CMD_REE 8'h03
`define PPP_ENTRY_GUARD_NS 100
`define PPP_ENTRY_TOGGLES 6
`define PPP_FLASH_AW 6
`define PPP_PAGE_WORDS 8
`define PPP_WORD_BITS 3
`define PPP_EE_AW 5
`define PPP_EE_PAGE 4
`define PPP_EE_WORD_BITS 2
`define PPP_FUSE_LOW_RST 8'h62
`define PPP_FUSE_HIGH_RST 8'h99
`define PPP_FUSE_EXT_RST 8'hFF
`define PPP_LOCK_RST 8'hFF
`define PPP_LOCK_MAIN_MASK 8'h03
`define PPP_LOCK_BOOT_MASK 8'h3C
`define PPP_KEEP_EE_BIT 3
`define PPP_FIFO_DEPTH 8
`define PPP_FIFO_AW 3
`define PPP_ERASED 8'hFF
`define PPP_SIG0 8'hA5
`define PPP_SIG1 8'h5A
`define PPP_SIG2 8'h3C
`define PPP_CAL_RST 8'h80
`define PPP_ADDR_SIG_MAX 8'h02
`endif

// ### design/ppp_fifo.v
/*
 Small flip-flop FIFO with valid/ready on both sides.
 Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module ppp_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW = 3
)
(
	// Clock and reset
	input wire mclk,
	input wire arst_n,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	integer i;

	assign in_ready = (cnt_q != DEPTH);
	assign out_valid = (cnt_q != 0);
	assign out_data = mem_q[rp_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1)
				mem_q[i] <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem_q[wp_q] <= in_data;
				wp_q <= wp_q + 1'b1;
			end
			if (pop)
				rp_q <= rp_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// ### design/ppp_port.v
/*
 Parallel programming port: command, address and data loading, page buffers
 for Flash and EEPROM, self-timed write/erase engine, fuse and lock storage,
 read-back onto the data bus.
 Assumes all pins are asynchronous to mclk and strobes last several mclk
 periods; the high-voltage reset is seen as the level hv_reset.
*/
`timescale 1ns/1ps
`include "ppp_defines.vh"

// Contract
// - Entry-select pins low before high voltage; change within 100 ns refuses entry.
// - Command and address registers persist across operations.
// - Chip erase clears Flash, locks, EEPROM unless keep fuse; fuses kept.
// - Lock bits cleared only after program memory fully erased.
// - Chip erase command 80 then program strobe; busy low until done.
// - Flash data gathered in page buffer, whole page programmed at once.
// - Command 10 selects Flash page write.
// - Action 00 loads address low or high byte by low byte select.
// - Action 01 loads data low or high byte by low byte select.
// - Page-latch pulse with low byte select 1 stores data in buffer.
// - Low address bits index word in page, upper bits index page.
// - Program strobe low starts page programming; busy low until done.
// - Command 00 ends page programming and resets write controls.
// - Command 11 EEPROM page write via latch then program strobe.
// - Command 02 reads Flash low or high byte with output enable low.
// - Command 03 reads addressed EEPROM byte with output enable low.
// - Command 40 writes data low byte to fuse group chosen by selects; code skips the write while main lock bits are programmed.
// - Command 20 programs zero lock bits; boot locks frozen when main locked.
// - Command 04 reads fuse or lock byte chosen by byte selects.
// - Command 08 reads identification bytes or calibration byte.
// - Action strobe acts by select: address, data, command, or nothing.
// - Ready/busy low during operation, high when ready.
// - Data bus input except while output enable low.
module ppp_port #(
	parameter OP_CYCLES = 32'd74000,
	parameter ERASE_CYCLES = 32'd150000
)
(
	// Clock and reset
	input wire mclk,
	input wire arst_n,
	// Programming pins
	input wire hv_reset,
	input wire action_strobe,
	input wire action_select_high,
	input wire action_select_low,
	input wire low_byte_select,
	input wire high_byte_select,
	input wire page_latch_strobe,
	input wire write_strobe_n,
	input wire output_enable_n,
	input wire [7:0] data_in,
	output reg [7:0] data_out,
	output reg data_oe,
	output reg ready_busy,
	// Status
	output reg prog_mode,
	output reg [7:0] lock_bits_q
);
	localparam GUARD_CYC = (`PPP_ENTRY_GUARD_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS;
	localparam ST_IDLE = 3'b001;
	localparam ST_BUSY = 3'b010;
	localparam ST_LOCKCLR = 3'b100;

	reg [10:0] s1_q;
	reg [10:0] s2_q;
	reg [10:0] s3_q;
	wire [10:0] pin_raw = {hv_reset, action_strobe, action_select_high, action_select_low,
		low_byte_select, high_byte_select, page_latch_strobe, write_strobe_n, output_enable_n, 2'b00};
	reg [7:0] d1_q;
	reg [7:0] d2_q;
	wire hv = s2_q[10];
	wire xs_rise = s2_q[9] & ~s3_q[9];
	wire [1:0] act = s2_q[8:7];
	wire bsl = s2_q[6];
	wire bsh = s2_q[5];
	wire pl_rise = s2_q[4] & ~s3_q[4];
	wire wr_fall = ~s2_q[3] & s3_q[3];
	wire oe_n = s2_q[2];
	wire [3:0] sel_pins = {s2_q[4], s2_q[8], s2_q[7], s2_q[6]};

	reg [7:0] cmd_q;
	reg [7:0] alo_q;
	reg [7:0] ahi_q;
	reg [7:0] dlo_q;
	reg [7:0] dhi_q;
	reg [7:0] fuse_lo_q;
	reg [7:0] fuse_hi_q;
	reg [7:0] fuse_ex_q;
	reg [15:0] fbuf_q [0:`PPP_PAGE_WORDS-1];
	reg [15:0] flash_q [0:(1<<`PPP_FLASH_AW)-1];
	reg [7:0] ebuf_q [0:`PPP_EE_PAGE-1];
	reg [7:0] ee_q [0:(1<<`PPP_EE_AW)-1];
	reg [2:0] st_q;
	reg [31:0] tmr_q;
	reg [7:0] op_q;
	reg [3:0] tog_q;
	reg [3:0] gcnt_q;
	reg hv_d_q;
	reg refused_q;
	reg armed_q;
	reg [`PPP_FLASH_AW-1:0] fpage_base_q;
	reg [`PPP_EE_AW-1:0] epage_base_q;
	integer k;
	integer m;

	wire cmd_ok = (cmd_q == `PPP_CMD_ERASE) || (cmd_q == `PPP_CMD_WFUSE) || (cmd_q == `PPP_CMD_WLOCK) ||
		(cmd_q == `PPP_CMD_WFLASH) || (cmd_q == `PPP_CMD_WEE) || (cmd_q == `PPP_CMD_RSIG) ||
		(cmd_q == `PPP_CMD_RFUSE) || (cmd_q == `PPP_CMD_RFLASH) || (cmd_q == `PPP_CMD_REE);
	wire idle = (st_q == ST_IDLE);
	wire [`PPP_FLASH_AW-1:0] faddr = alo_q[`PPP_FLASH_AW-1:0];
	wire [`PPP_EE_AW-1:0] eaddr = alo_q[`PPP_EE_AW-1:0];
	wire [`PPP_WORD_BITS-1:0] fword = alo_q[`PPP_WORD_BITS-1:0];
	wire [`PPP_EE_WORD_BITS-1:0] eword = alo_q[`PPP_EE_WORD_BITS-1:0];
	wire keep_eeprom_fuse = ~fuse_hi_q[`PPP_KEEP_EE_BIT];
	wire main_locked = ((lock_bits_q & `PPP_LOCK_MAIN_MASK) == 8'h00);

	// Flash page writes pass through the FIFO into the Flash array; EEPROM pages are written directly
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [21:0] fifo_out;
	reg fifo_push;
	reg [21:0] fifo_wdata;
	reg [`PPP_WORD_BITS:0] wcnt_q;
	reg drain_q;

	ppp_fifo #(.WIDTH(22), .DEPTH(`PPP_FIFO_DEPTH), .AW(`PPP_FIFO_AW)) u_fifo (
		.mclk(mclk),
		.arst_n(arst_n),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(fifo_wdata),
		.out_valid(fifo_out_valid),
		.out_ready(drain_q),
		.out_data(fifo_out)
	);

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_q <= 11'h000;
			s2_q <= 11'h000;
			s3_q <= 11'h000;
			d1_q <= 8'h00;
			d2_q <= 8'h00;
		end
		else
		begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			d1_q <= data_in;
			d2_q <= d1_q;
		end
	end

	// Entry: count strobe toggles while reset low, then watch select pins after high voltage
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tog_q <= 4'h0;
			gcnt_q <= 4'h0;
			hv_d_q <= 1'b0;
			refused_q <= 1'b0;
			armed_q <= 1'b0;
			prog_mode <= 1'b0;
		end
		else
		begin
			hv_d_q <= hv;
			if (!hv)
			begin
				prog_mode <= 1'b0;
				refused_q <= 1'b0;
				gcnt_q <= 4'h0;
				if (xs_rise && tog_q != `PPP_ENTRY_TOGGLES)
					tog_q <= tog_q + 4'h1;
				armed_q <= (tog_q == `PPP_ENTRY_TOGGLES) && (sel_pins == 4'h0);
			end
			else if (!hv_d_q)
				gcnt_q <= 4'h1;
			else if (gcnt_q != 4'h0 && !prog_mode && !refused_q)
			begin
				if (sel_pins != 4'h0 || !armed_q)
					refused_q <= 1'b1;
				else if (gcnt_q == GUARD_CYC)
					prog_mode <= 1'b1;
				else
					gcnt_q <= gcnt_q + 4'h1;
			end
		end
	end

	// Loading, page latch, write engine
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cmd_q <= `PPP_CMD_NOP;
			alo_q <= 8'h00;
			ahi_q <= 8'h00;
			dlo_q <= 8'h00;
			dhi_q <= 8'h00;
			fuse_lo_q <= `PPP_FUSE_LOW_RST;
			fuse_hi_q <= `PPP_FUSE_HIGH_RST;
			fuse_ex_q <= `PPP_FUSE_EXT_RST;
			lock_bits_q <= `PPP_LOCK_RST;
			st_q <= ST_IDLE;
			tmr_q <= 32'd0;
			op_q <= `PPP_CMD_NOP;
			ready_busy <= 1'b1;
			wcnt_q <= {(`PPP_WORD_BITS+1){1'b0}};
			fpage_base_q <= {`PPP_FLASH_AW{1'b0}};
			epage_base_q <= {`PPP_EE_AW{1'b0}};
			for (k = 0; k < `PPP_PAGE_WORDS; k = k + 1)
				fbuf_q[k] <= 16'hFFFF;
			for (k = 0; k < `PPP_EE_PAGE; k = k + 1)
				ebuf_q[k] <= `PPP_ERASED;
		end
		else
		begin
			if (prog_mode && idle && xs_rise)
			begin
				case (act)
				`PPP_ACT_ADDR:
					if (bsl)
						ahi_q <= d2_q;
					else
						alo_q <= d2_q;
				`PPP_ACT_DATA:
					if (bsl)
						dhi_q <= d2_q;
					else
						dlo_q <= d2_q;
				`PPP_ACT_CMD:
				begin
					cmd_q <= d2_q;
					if (d2_q == `PPP_CMD_NOP)
					begin
						op_q <= `PPP_CMD_NOP;
						for (k = 0; k < `PPP_PAGE_WORDS; k = k + 1)
							fbuf_q[k] <= 16'hFFFF;
					end
				end
				default:
				begin
				end
				endcase
			end
			if (prog_mode && idle && pl_rise)
			begin
				if (cmd_q == `PPP_CMD_WFLASH && bsl)
					fbuf_q[fword] <= {dhi_q, dlo_q};
				else if (cmd_q == `PPP_CMD_WEE)
					ebuf_q[eword] <= dlo_q;
			end
			case (st_q)
			ST_IDLE:
				if (prog_mode && wr_fall && cmd_ok)
				begin
					ready_busy <= 1'b0;
					op_q <= cmd_q;
					wcnt_q <= {(`PPP_WORD_BITS+1){1'b0}};
					fpage_base_q <= {faddr[`PPP_FLASH_AW-1:`PPP_WORD_BITS], {`PPP_WORD_BITS{1'b0}}};
					epage_base_q <= {eaddr[`PPP_EE_AW-1:`PPP_EE_WORD_BITS], {`PPP_EE_WORD_BITS{1'b0}}};
					st_q <= ST_BUSY;
					if (cmd_q == `PPP_CMD_ERASE)
						tmr_q <= ERASE_CYCLES;
					else
						tmr_q <= OP_CYCLES;
					if (cmd_q == `PPP_CMD_WFUSE && !main_locked)
					begin
						if (!bsl && !bsh)
							fuse_lo_q <= dlo_q;
						else if (bsl && !bsh)
							fuse_hi_q <= dlo_q;
						else if (!bsl && bsh)
							fuse_ex_q <= dlo_q;
					end
					if (cmd_q == `PPP_CMD_WLOCK)
					begin
						if (main_locked)
							lock_bits_q <= lock_bits_q & (dlo_q | `PPP_LOCK_BOOT_MASK);
						else
							lock_bits_q <= lock_bits_q & dlo_q;
					end
				end
			ST_BUSY:
			begin
				if (op_q == `PPP_CMD_WFLASH && wcnt_q != `PPP_PAGE_WORDS && fifo_in_ready)
					wcnt_q <= wcnt_q + 1'b1;
				if (tmr_q > 32'd1)
					tmr_q <= tmr_q - 32'd1;
				else if (fifo_out_valid)
					tmr_q <= 32'd1;
				else if (op_q == `PPP_CMD_ERASE)
					st_q <= ST_LOCKCLR;
				else
				begin
					st_q <= ST_IDLE;
					ready_busy <= 1'b1;
				end
			end
			ST_LOCKCLR:
			begin
				lock_bits_q <= `PPP_LOCK_RST;
				st_q <= ST_IDLE;
				ready_busy <= 1'b1;
			end
			default:
				st_q <= ST_IDLE;
			endcase
		end
	end

	always @*
	begin
		fifo_push = (st_q == ST_BUSY) && (op_q == `PPP_CMD_WFLASH) && (wcnt_q != `PPP_PAGE_WORDS);
		fifo_wdata = {fpage_base_q | {{(`PPP_FLASH_AW-`PPP_WORD_BITS){1'b0}}, wcnt_q[`PPP_WORD_BITS-1:0]},
			fbuf_q[wcnt_q[`PPP_WORD_BITS-1:0]]};
	end

	// Memory arrays; FIFO drains every other cycle so writes can queue up
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			drain_q <= 1'b0;
			for (m = 0; m < (1<<`PPP_FLASH_AW); m = m + 1)
				flash_q[m] <= 16'hFFFF;
			for (m = 0; m < (1<<`PPP_EE_AW); m = m + 1)
				ee_q[m] <= `PPP_ERASED;
		end
		else
		begin
			drain_q <= ~drain_q;
			if (fifo_out_valid && drain_q)
				flash_q[fifo_out[21:16]] <= flash_q[fifo_out[21:16]] & fifo_out[15:0];
			if (st_q == ST_BUSY && op_q == `PPP_CMD_WEE && tmr_q == OP_CYCLES)
				for (m = 0; m < `PPP_EE_PAGE; m = m + 1)
					ee_q[epage_base_q + m] <= ee_q[epage_base_q + m] & ebuf_q[m];
			if (st_q == ST_BUSY && op_q == `PPP_CMD_ERASE && tmr_q == ERASE_CYCLES)
			begin
				for (m = 0; m < (1<<`PPP_FLASH_AW); m = m + 1)
					flash_q[m] <= 16'hFFFF;
				if (!keep_eeprom_fuse)
					for (m = 0; m < (1<<`PPP_EE_AW); m = m + 1)
						ee_q[m] <= `PPP_ERASED;
			end
		end
	end

	// Read-back onto the data bus
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			data_out <= 8'h00;
			data_oe <= 1'b0;
		end
		else
		begin
			data_oe <= prog_mode && !oe_n && cmd_ok;
			case (cmd_q)
			`PPP_CMD_RFLASH:
				data_out <= bsl ? flash_q[faddr][15:8] : flash_q[faddr][7:0];
			`PPP_CMD_REE:
				data_out <= ee_q[eaddr];
			`PPP_CMD_RFUSE:
				case ({bsh, bsl})
				2'b00: data_out <= fuse_lo_q;
				2'b11: data_out <= fuse_hi_q;
				2'b10: data_out <= fuse_ex_q;
				default: data_out <= lock_bits_q;
				endcase
			`PPP_CMD_RSIG:
				if (bsl)
					data_out <= `PPP_CAL_RST;
				else if (alo_q == 8'h00)
					data_out <= `PPP_SIG0;
				else if (alo_q == 8'h01)
					data_out <= `PPP_SIG1;
				else if (alo_q == `PPP_ADDR_SIG_MAX)
					data_out <= `PPP_SIG2;
				else
					data_out <= 8'h00;
			default:
				data_out <= 8'h00;
			endcase
		end
	end
endmodule

// ### verification/ppp_port_asserts.sv
/*
 Checker of the programming port pin timing.
 Assumes it is bound into ppp_port and sees its ports only.
*/
`timescale 1ns/1ps
`include "ppp_defines.vh"
module ppp_port_asserts #(
	parameter OP_CYCLES = 32'd74000,
	parameter ERASE_CYCLES = 32'd150000
)
(
	// Clock and reset
	input wire mclk,
	input wire arst_n,
	// Pins
	input wire hv_reset,
	input wire action_strobe,
	input wire action_select_high,
	input wire action_select_low,
	input wire low_byte_select,
	input wire high_byte_select,
	input wire page_latch_strobe,
	input wire write_strobe_n,
	input wire output_enable_n,
	input wire [7:0] data_in,
	input wire [7:0] data_out,
	input wire data_oe,
	input wire ready_busy,
	// Status
	input wire prog_mode,
	input wire [7:0] lock_bits_q
);
	reg [31:0] busy_n_q;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	// Length of the running busy phase
	always @(posedge mclk or negedge arst_n)
		if (!arst_n)
			busy_n_q <= 32'h0;
		else
			busy_n_q <= ready_busy ? 32'h0 : busy_n_q + 32'h1;
	AST_ENTRY: assert property ($rose(prog_mode) |-> $past(hv_reset, 4) &&
		!page_latch_strobe && !action_select_high && !action_select_low && !low_byte_select)
		else $error("mode entered without entry conditions");
	AST_BUSY_START: assert property ($fell(ready_busy) |->
		!$past(write_strobe_n, 3) || !$past(write_strobe_n, 4))
		else $error("busy without write strobe");
	AST_BUSY_LEN: assert property ($rose(ready_busy) |-> busy_n_q >= OP_CYCLES)
		else $error("busy phase too short");
	AST_BUSY_MAX: assert property (!ready_busy |-> busy_n_q <= ERASE_CYCLES + 32'd16)
		else $error("busy phase too long");
	AST_LOCK_WHEN: assert property ($changed(lock_bits_q) |-> !ready_busy || !$past(ready_busy))
		else $error("lock bits changed while idle");
	AST_LOCK_UP: assert property ((lock_bits_q & ~$past(lock_bits_q)) != 8'h00 |->
		lock_bits_q == `PPP_LOCK_RST)
		else $error("lock bit cleared without full erase");
	AST_OE_ON: assert property ($rose(data_oe) |-> !$past(output_enable_n, 2) && prog_mode)
		else $error("bus driven without output enable");
	AST_OE_OFF: assert property (output_enable_n [*5] |-> !data_oe)
		else $error("bus still driven after output enable");
	COV_ENTRY: cover property ($rose(prog_mode));
	COV_BUSY: cover property ($rose(ready_busy));
	COV_DRIVE: cover property ($rose(data_oe));
endmodule
bind ppp_port ppp_port_asserts #(.OP_CYCLES(OP_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_chk (
	.mclk(mclk),
	.arst_n(arst_n),
	.hv_reset(hv_reset),
	.action_strobe(action_strobe),
	.action_select_high(action_select_high),
	.action_select_low(action_select_low),
	.low_byte_select(low_byte_select),
	.high_byte_select(high_byte_select),
	.page_latch_strobe(page_latch_strobe),
	.write_strobe_n(write_strobe_n),
	.output_enable_n(output_enable_n),
	.data_in(data_in),
	.data_out(data_out),
	.data_oe(data_oe),
	.ready_busy(ready_busy),
	.prog_mode(prog_mode),
	.lock_bits_q(lock_bits_q)
);

// ### verification/ppp_prog.sv
/*
 Parallel programmer model: strobes, selects and data bus.
 Assumes tasks are entered at a rising mclk edge.
*/
`timescale 1ns/1ps
module ppp_prog (
	// Clock
	input wire mclk,
	// Device answers
	input wire [7:0] data_out,
	input wire data_oe,
	input wire ready_busy,
	// Programming pins
	output reg hv_reset = 1'b0,
	output reg action_strobe = 1'b0,
	output reg action_select_high = 1'b0,
	output reg action_select_low = 1'b0,
	output reg low_byte_select = 1'b0,
	output reg high_byte_select = 1'b0,
	output reg page_latch_strobe = 1'b0,
	output reg write_strobe_n = 1'b1,
	output reg output_enable_n = 1'b1,
	output reg [7:0] bus_q = 8'h00
);
	task step(input integer n);
		repeat (n) @(posedge mclk);
	endtask
	task enter;
		repeat (6)
		begin
			action_strobe <= 1'b1;
			step(4);
			action_strobe <= 1'b0;
			step(4);
		end
		step(4);
		hv_reset <= 1'b1;
		step(1010);
	endtask
	// Moves a select pin inside the guard time after the voltage arrives
	task enter_bad;
		hv_reset <= 1'b0;
		{action_select_high, action_select_low} <= 2'b00;
		low_byte_select <= 1'b0;
		step(8);
		hv_reset <= 1'b1;
		step(1);
		page_latch_strobe <= 1'b1;
		step(8);
		page_latch_strobe <= 1'b0;
		step(4);
	endtask
	// Bus is inverted once its hold ends
	task load(input [1:0] act, input b1, input [7:0] d);
		{action_select_high, action_select_low} <= act;
		low_byte_select <= b1;
		bus_q <= d;
		step(4);
		action_strobe <= 1'b1;
		step(4);
		action_strobe <= 1'b0;
		step(4);
		bus_q <= ~d;
		{action_select_high, action_select_low} <= 2'b11;
		step(1);
	endtask
	task latch(input b1);
		low_byte_select <= b1;
		step(4);
		page_latch_strobe <= 1'b1;
		step(4);
		page_latch_strobe <= 1'b0;
		step(4);
	endtask
	// Counts busy cycles until ready returns
	task wr(input b1, input b2, output integer n);
		integer i;
		low_byte_select <= b1;
		high_byte_select <= b2;
		step(4);
		write_strobe_n <= 1'b0;
		n = 0;
		for (i = 0; i < 400; i++)
		begin
			@(negedge mclk);
			n += !ready_busy;
			if (ready_busy && i > 8)
				break;
			@(posedge mclk);
			write_strobe_n <= i < 3 ? 1'b0 : 1'b1;
		end
		@(posedge mclk);
		high_byte_select <= 1'b0;
	endtask
	task rd(input b2, input b1, output [8:0] v);
		high_byte_select <= b2;
		low_byte_select <= b1;
		output_enable_n <= 1'b0;
		step(6);
		@(negedge mclk);
		v = {data_oe, data_out};
		@(posedge mclk);
		output_enable_n <= 1'b1;
		high_byte_select <= 1'b0;
		step(6);
	endtask
endmodule

// ### verification/tb.sv
/*
 Self-checking bench of the parallel programming port.
 Assumes ppp_prog drives every pin and the checker is bound in.
*/
`timescale 1ns/1ps
`include "ppp_defines.vh"
module tb;
	localparam OPC = 20;
	localparam ERC = 40;
	reg mclk = 1'b0;
	reg arst_n = 1'b0;
	wire hv_reset, action_strobe, action_select_high, action_select_low, low_byte_select;
	wire high_byte_select, page_latch_strobe, write_strobe_n, output_enable_n, data_oe, ready_busy, prog_mode;
	wire [7:0] bus_q, data_out, lock_bits_q;
	wire [7:0] data_in = data_oe ? data_out : bus_q;
	integer fail_count = 0;
	integer num_checks = 0;
	integer n;
	reg [7:0] k;
	reg [8:0] v;
	reg [7:0] fz [0:2] = '{8'hE2, 8'h91, 8'hFD};
	reg [7:0] sig [0:2] = '{`PPP_SIG0, `PPP_SIG1, `PPP_SIG2};
	always #25 mclk = ~mclk;
	ppp_port #(.OP_CYCLES(OPC), .ERASE_CYCLES(ERC)) dut (
		.mclk(mclk),
		.arst_n(arst_n),
		.hv_reset(hv_reset),
		.action_strobe(action_strobe),
		.action_select_high(action_select_high),
		.action_select_low(action_select_low),
		.low_byte_select(low_byte_select),
		.high_byte_select(high_byte_select),
		.page_latch_strobe(page_latch_strobe),
		.write_strobe_n(write_strobe_n),
		.output_enable_n(output_enable_n),
		.data_in(data_in),
		.data_out(data_out),
		.data_oe(data_oe),
		.ready_busy(ready_busy),
		.prog_mode(prog_mode),
		.lock_bits_q(lock_bits_q)
	);
	ppp_prog prog (
		.mclk(mclk),
		.data_out(data_out),
		.data_oe(data_oe),
		.ready_busy(ready_busy),
		.hv_reset(hv_reset),
		.action_strobe(action_strobe),
		.action_select_high(action_select_high),
		.action_select_low(action_select_low),
		.low_byte_select(low_byte_select),
		.high_byte_select(high_byte_select),
		.page_latch_strobe(page_latch_strobe),
		.write_strobe_n(write_strobe_n),
		.output_enable_n(output_enable_n),
		.bus_q(bus_q)
	);
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input [8:0] got, input [8:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task chk_n(input integer got, input integer lo, input integer hi);
		num_checks++;
		if ($isunknown(got) || got < lo || got > hi)
		begin
			fail_count++;
			$display("[FAIL] %0t busy %0d cycles", $time, got);
		end
		if (got > 380)
			test_done;
	endtask
	task cmd(input [7:0] c);
		prog.load(`PPP_ACT_CMD, 1'b0, c);
	endtask
	task wr(input b1, input b2, input integer lo, input integer hi);
		prog.wr(b1, b2, n);
		chk_n(n, lo, hi);
	endtask
	task rd(input b2, input b1, input [7:0] e);
		prog.rd(b2, b1, v);
		chk(v, {1'b1, e});
	endtask
	initial
	begin
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		prog.enter;
		chk({8'h00, prog_mode}, 9'h001);
		cmd(`PPP_CMD_ERASE);
		wr(0, 0, ERC, ERC + 12);
		$display("entry and erase done");
		cmd(`PPP_CMD_WFLASH);
		for (k = 0; k < 2; k++)
		begin
			prog.load(`PPP_ACT_ADDR, 1'b0, 8'h08 + k);
			prog.load(`PPP_ACT_DATA, 1'b0, 8'hC0 + k);
			prog.load(`PPP_ACT_DATA, 1'b1, 8'h10 + k);
			prog.latch(1'b1);
		end
		prog.load(`PPP_ACT_ADDR, 1'b1, 8'h00);
		wr(0, 0, OPC, OPC + 16);
		cmd(`PPP_CMD_NOP);
		cmd(`PPP_CMD_RFLASH);
		for (k = 0; k < 3; k++)
		begin
			prog.load(`PPP_ACT_ADDR, 1'b0, k < 2 ? 8'h08 + k : 8'h00);
			rd(0, 0, k < 2 ? 8'hC0 + k : `PPP_ERASED);
			rd(0, 1, k < 2 ? 8'h10 + k : `PPP_ERASED);
		end
		$display("flash done");
		cmd(`PPP_CMD_WEE);
		prog.load(`PPP_ACT_ADDR, 1'b1, 8'h00);
		prog.load(`PPP_ACT_ADDR, 1'b0, 8'h05);
		prog.load(`PPP_ACT_DATA, 1'b0, 8'h5A);
		prog.latch(1'b1);
		wr(0, 0, OPC, OPC + 16);
		cmd(`PPP_CMD_REE);
		rd(0, 0, 8'h5A);
		cmd(`PPP_CMD_WFUSE);
		for (k = 0; k < 3; k++)
		begin
			prog.load(`PPP_ACT_DATA, 1'b0, fz[k]);
			wr(k == 1, k == 2, OPC, OPC + 16);
		end
		cmd(`PPP_CMD_RFUSE);
		rd(0, 0, fz[0]);
		rd(1, 1, fz[1]);
		rd(1, 0, fz[2]);
		rd(0, 1, `PPP_LOCK_RST);
		$display("eeprom and fuse done");
		cmd(`PPP_CMD_WLOCK);
		prog.load(`PPP_ACT_DATA, 1'b0, 8'hFC);
		wr(0, 0, OPC, OPC + 16);
		prog.load(`PPP_ACT_DATA, 1'b0, 8'hF0);
		wr(0, 0, OPC, OPC + 16);
		chk({1'b1, lock_bits_q}, 9'h1FC);
		cmd(`PPP_CMD_WFUSE);
		prog.load(`PPP_ACT_DATA, 1'b0, 8'h00);
		wr(0, 0, OPC, OPC + 16);
		cmd(8'h55);
		wr(0, 0, 0, 0);
		prog.rd(0, 0, v);
		chk({v[8], 8'h00}, 9'h000);
		cmd(`PPP_CMD_ERASE);
		wr(0, 0, ERC, ERC + 12);
		chk({1'b1, lock_bits_q}, {1'b1, `PPP_LOCK_RST});
		cmd(`PPP_CMD_REE);
		rd(0, 0, 8'h5A);
		cmd(`PPP_CMD_RFLASH);
		prog.load(`PPP_ACT_ADDR, 1'b0, 8'h08);
		rd(0, 0, `PPP_ERASED);
		cmd(`PPP_CMD_RFUSE);
		rd(0, 0, fz[0]);
		$display("lock and erase done");
		cmd(`PPP_CMD_RSIG);
		for (k = 0; k < 3; k++)
		begin
			prog.load(`PPP_ACT_ADDR, 1'b0, k);
			rd(0, 0, sig[k]);
		end
		prog.load(`PPP_ACT_ADDR, 1'b0, 8'h00);
		rd(0, 1, `PPP_CAL_RST);
		$display("signature done");
		prog.enter_bad;
		chk({8'h00, prog_mode}, 9'h000);
		$display("entry refusal done");
		test_done;
	end
endmodule
